// ### ctl_cfg.svh
// register map, field positions and reset values of the two-wire control block
`ifndef CTL_CFG_SVH
`define CTL_CFG_SVH
`define IDX_MAIN_CONFIG   10'h000
`define IDX_BUS_COMMAND   10'h001
`define IDX_FLAG_VIEW     10'h010
`define IDX_IRQ_ENABLE    10'h011
`define MAIN_CONFIG_RST   8'h00
`define BUS_COMMAND_RST   8'h00
`define IRQ_ENABLE_RST    3'h0
`define MAIN_CONFIG_MASK  8'hFB
`define BUS_COMMAND_MASK  8'hBF
`define B_HOLD_SCL_OFF    7
`define B_GC_ACCEPT       6
`define B_CRC_CALC_ON     5
`define B_ARP_ENABLE      4
`define B_HOST_ROLE_SEL   3
`define B_SMB_PROTO_SEL   1
`define B_UNIT_ON         0
`define B_SOFT_HOLD_RST   7
`define B_ALERT_DRIVE     5
`define B_CRC_XFER_REQ    4
`define B_ACK_NEXT_SEL    3
`define B_ACK_ENABLE      2
`define B_STOP_REQ        1
`define B_START_REQ       0
`define B_ERROR_IRQ_ON    0
`define B_EVENT_IRQ_ON    1
`define B_BUFFER_IRQ_ON   2
`endif

// ### ctl_pkg.sv
// types shared by the two-wire control block
package ctl_pkg;
  typedef struct packed {
    logic [7:0]  main_config;
    logic [7:0]  bus_command;
    logic [2:0]  irq_enable;
    logic        unit_live;
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic        scl_prev;
    logic        sda_prev;
    logic        busy;
    logic        start_seen;
    logic        stop_seen;
    logic        pend;
    logic        pend_wr;
    logic        pend_hit;
    logic [9:0]  pend_idx;
    logic [31:0] rdata;
    logic        ready;
    logic        evt_irq;
    logic        err_irq;
    logic        wake_wait;
    logic        wake_halt;
    logic        stretch;
    logic        addr_ack;
    logic        alert_oe;
    logic        crc_on;
    logic        smbus_mode;
    logic        ack_next;
    logic        data_ack;
    logic        crc_req;
    logic        stop_req;
    logic        start_req;
    logic        hold_reset;
  } ctl_state_type;
endpackage

// ### i2c_ctl.sv
// two-wire bus control registers, interrupt mapping and wake routing
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "ctl_cfg.svh"

// Behaviour
// - event flags raise event request when enabled
// - buffer flags need event and buffer enables
// - events wake wait; halt wake only
// - slave stretches on hit/byte unless disabled
// - general call acked only when accepted
// - checksum calculation follows its enable bit
// - arp recognises device or host address
// - protocol select; reserved bit reads zero
// - disable deferred until bus idle
// - soft reset holds interface in reset
// - alert bit drives line, acks alert header
// - checksum request cleared by hardware events
// - arbitration loss may corrupt checksum
// - position bit selects current or next byte
// - ack enable acks every received byte
// - stop cleared on stop, set on timeout
// - stop request ends master or releases slave
// - start request cleared when sent or disabled
// - both control registers reset to zero
module i2c_ctl
  import ctl_pkg::*;
#(
  parameter int IDX_W = 10
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // bus pins as seen by the block
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  input  wire logic        ALERT_IN,
  output logic             ALERT_OUT,
  output logic             ALERT_OE,
  // flags from the protocol engine
  input  wire logic        START_SENT_FLAG,
  input  wire logic        TARGET_HIT_FLAG,
  input  wire logic        TEN_BIT_HEADER_FLAG,
  input  wire logic        STOP_SEEN_FLAG,
  input  wire logic        BYTE_DONE_FLAG,
  input  wire logic        HALT_WAKE_FLAG,
  input  wire logic        RX_HOLDING_FULL,
  input  wire logic        TX_HOLDING_EMPTY,
  input  wire logic        MISPLACED_COND_FLAG,
  input  wire logic        ARB_LOST_FLAG,
  input  wire logic        NAK_FAULT_FLAG,
  input  wire logic        OVERFLOW_UNDERFLOW_FLAG,
  input  wire logic        CRC_MISMATCH_FLAG,
  input  wire logic        TIMEOUT_FLAG,
  input  wire logic        SMBUS_ALERT_FLAG,
  // engine status and one-cycle events
  input  wire logic        SLAVE_MODE,
  input  wire logic        START_DONE,
  input  wire logic        CRC_SENT,
  input  wire logic        TIMEOUT_EVT,
  // received address class from the engine
  input  wire logic        ADDR_OWN,
  input  wire logic        ADDR_GEN_CALL,
  input  wire logic        ADDR_DEV_DEFAULT,
  input  wire logic        ADDR_HOST,
  input  wire logic        ADDR_ALERT_RESP,
  // controls to the engine and the system
  output logic             EVENT_IRQ,
  output logic             ERROR_IRQ,
  output logic             WAKE_WAIT,
  output logic             WAKE_HALT,
  output logic             SCL_STRETCH,
  output logic             ADDR_ACK,
  output logic             DATA_ACK,
  output logic             ACK_NEXT_SEL,
  output logic             CRC_CALC_ON,
  output logic             CRC_XFER_REQ,
  output logic             SMBUS_MODE,
  output logic             PINS_OWNED,
  output logic             STOP_REQ,
  output logic             START_REQ,
  output logic             ENGINE_RESET
);

  // register map, one aligned word per register, data in bits 7:0
  //   byte 0x00 main_config
  //     bit 7 hold_scl_off: no slave clock stretching
  //     bit 6 general_call_accept: answer address zero
  //     bit 5 crc_calc_on: checksum engine running
  //     bit 4 arp_enable: smbus default or host address
  //     bit 3 host_role_sel: 0 device, 1 host
  //     bit 2 reserved, reads zero, writes dropped
  //     bit 1 smb_protocol_sel: 0 plain, 1 smbus
  //     bit 0 unit_on: pins to the interface
  //   byte 0x04 bus_command
  //     bit 7 soft_hold_reset: engine held in reset
  //     bit 6 reserved, reads zero, writes dropped
  //     bit 5 alert drive: pull the alert line low
  //     bit 4 checksum transfer or check request
  //     bit 3 ack_next_sel: current or next byte
  //     bit 2 acknowledge enable
  //     bit 1 stop request
  //     bit 0 start request
  //   byte 0x40 flag view, read only
  //     bits 3:0 error irq, event irq, busy, unit live
  //   byte 0x44 irq enable
  //     bits 2:0 buffer, event, error enables
  //   any other word reads zero and ignores writes
  //   unaligned or high addresses read zero as well
  //
  // bus timing
  //   address phase taken with ready high
  //   one wait state, ready low for one cycle
  //   write lands and read data loads at the next edge
  //   response is always okay; no transfer is refused
  //   size is ignored; whole words only
  //
  // pin timing
  //   two sync flops plus one edge stage on each line
  //   start or stop acts about four cycles after the pin
  //   glitches shorter than a clock may be missed
  //   busy set by a start, cleared by a stop or soft reset

  // the stored index field is fixed at ten bits
  generate
    if (IDX_W != 10) begin : g_bad
      $error("IDX_W must be 10 to fit the stored index");
    end
  endgenerate

  // all state in one packed struct, next copy built combinationally
  ctl_state_type s_reg;
  ctl_state_type s_next;

  // helpers read by the next-state logic
  logic [7:0] cfg;
  logic [7:0] cmd;
  logic       evt_any;
  logic       buf_any;
  logic       err_any;
  logic       scl_hi;
  logic [7:0] wbyte;

  // shorthands on the stored registers
  assign cfg    = s_reg.main_config;
  assign cmd    = s_reg.bus_command;
  assign scl_hi = s_reg.scl_sync[1] & s_reg.scl_prev;
  assign wbyte  = HWDATA[7:0];

  // raw flag groups feeding the requests
  assign evt_any = START_SENT_FLAG | TARGET_HIT_FLAG | TEN_BIT_HEADER_FLAG
                 | STOP_SEEN_FLAG | BYTE_DONE_FLAG | HALT_WAKE_FLAG;
  // buffer flags carry their own enable, applied below
  assign buf_any = RX_HOLDING_FULL | TX_HOLDING_EMPTY;
  assign err_any = MISPLACED_COND_FLAG | ARB_LOST_FLAG | NAK_FAULT_FLAG
                 | OVERFLOW_UNDERFLOW_FLAG | CRC_MISMATCH_FLAG | TIMEOUT_FLAG
                 | SMBUS_ALERT_FLAG;

  // priority inside one cycle, last assignment wins:
  //   hardware clears first, then a software write in its data
  //   phase, then a timeout, which sets the stop bit
  //   so a write in the clearing cycle keeps what software wrote
  // next-state logic for the whole block
  always_comb begin
    s_next = s_reg;

    // pins: two flops, then one more stage for edge finding
    // only the second flop is read; the first may be metastable
    s_next.scl_sync = {s_reg.scl_sync[0], SCL_IN};
    s_next.sda_sync = {s_reg.sda_sync[0], SDA_IN};
    s_next.scl_prev = s_reg.scl_sync[1];
    s_next.sda_prev = s_reg.sda_sync[1];
    // start: data falls while clock high; stop: data rises
    s_next.start_seen = scl_hi & s_reg.sda_prev & ~s_reg.sda_sync[1];
    s_next.stop_seen  = scl_hi & ~s_reg.sda_prev & s_reg.sda_sync[1];

    // bus busy tracker, wiped by the soft reset
    // busy also holds off the deferred disable below
    if (cmd[`B_SOFT_HOLD_RST]) begin
      s_next.busy = 1'b0;
    end else if (s_reg.start_seen) begin
      s_next.busy = 1'b1;
    end else if (s_reg.stop_seen) begin
      s_next.busy = 1'b0;
    end

    // enabling is immediate, disabling waits for an idle bus
    // pins stay with the interface until the transfer has ended
    if (cfg[`B_UNIT_ON]) begin
      s_next.unit_live = 1'b1;
    end else if (!s_reg.busy) begin
      s_next.unit_live = 1'b0;
    end

    // hardware clears of the command bits
    // disable clears follow unit_live, not the raw enable bit
    if (!s_reg.unit_live) begin
      s_next.bus_command[`B_ALERT_DRIVE]  = 1'b0;
      s_next.bus_command[`B_CRC_XFER_REQ] = 1'b0;
      s_next.bus_command[`B_ACK_NEXT_SEL] = 1'b0;
      s_next.bus_command[`B_ACK_ENABLE]   = 1'b0;
      s_next.bus_command[`B_START_REQ]    = 1'b0;
    end
    // checksum request ends once sent or on any start or stop
    if (CRC_SENT | s_reg.start_seen | s_reg.stop_seen) begin
      s_next.bus_command[`B_CRC_XFER_REQ] = 1'b0;
    end
    if (s_reg.stop_seen) begin
      s_next.bus_command[`B_STOP_REQ] = 1'b0;
    end
    if (START_DONE) begin
      s_next.bus_command[`B_START_REQ] = 1'b0;
    end

    // ahb data phase: one wait state, then answer from a flop
    // no new address phase lands while a data phase is open,
    // since ready is low for that cycle
    s_next.ready = 1'b1;
    if (s_reg.pend) begin
      s_next.pend  = 1'b0;
      s_next.rdata = 32'h0000_0000;
      if (s_reg.pend_hit && s_reg.pend_wr) begin
        unique case (s_reg.pend_idx)
          `IDX_MAIN_CONFIG: s_next.main_config = wbyte & `MAIN_CONFIG_MASK;
          `IDX_BUS_COMMAND: s_next.bus_command = wbyte & `BUS_COMMAND_MASK;
          `IDX_IRQ_ENABLE:  s_next.irq_enable  = wbyte[2:0];
          default: ;
        endcase
      end else if (s_reg.pend_hit) begin
        unique case (s_reg.pend_idx)
          `IDX_MAIN_CONFIG: s_next.rdata[7:0] = cfg;
          `IDX_BUS_COMMAND: s_next.rdata[7:0] = cmd;
          `IDX_IRQ_ENABLE:  s_next.rdata[2:0] = s_reg.irq_enable;
          `IDX_FLAG_VIEW:   s_next.rdata[3:0] = {s_reg.err_irq, s_reg.evt_irq,
                                                 s_reg.busy, s_reg.unit_live};
          default: ;
        endcase
      end
    end else if (HSEL && HTRANS[1] && HREADY) begin
      s_next.pend     = 1'b1;
      s_next.ready    = 1'b0;
      s_next.pend_wr  = HWRITE;
      s_next.pend_idx = HADDR[IDX_W+1:2];
      s_next.pend_hit = (HADDR[31:IDX_W+2] == '0) && (HADDR[1:0] == 2'h0);
    end

    // a timeout sets stop last, so it beats a software clear
    if (TIMEOUT_EVT) begin
      s_next.bus_command[`B_STOP_REQ] = 1'b1;
    end

    // interrupt requests and wake-up routing
    // levels follow the engine flags; clearing them is the engine's job
    s_next.evt_irq = s_reg.irq_enable[`B_EVENT_IRQ_ON]
                   & (evt_any | (buf_any & s_reg.irq_enable[`B_BUFFER_IRQ_ON]));
    s_next.err_irq = s_reg.irq_enable[`B_ERROR_IRQ_ON] & err_any;

    // any request ends wait; halt ends only on the halt wake flag
    s_next.wake_wait = s_next.evt_irq | s_next.err_irq;
    s_next.wake_halt = s_reg.irq_enable[`B_EVENT_IRQ_ON] & HALT_WAKE_FLAG;

    // slave clock stretching until software clears the flag
    s_next.stretch = s_reg.unit_live & SLAVE_MODE & ~cfg[`B_HOLD_SCL_OFF]
                   & (TARGET_HIT_FLAG | BYTE_DONE_FLAG);

    // address acknowledge decision per address class
    // the alert response header needs only the alert bit
    s_next.addr_ack = s_reg.unit_live & (
        (ADDR_OWN & cmd[`B_ACK_ENABLE])
      | (ADDR_GEN_CALL & cfg[`B_GC_ACCEPT] & cmd[`B_ACK_ENABLE])
      | (ADDR_DEV_DEFAULT & cfg[`B_ARP_ENABLE] & ~cfg[`B_HOST_ROLE_SEL]
         & cmd[`B_ACK_ENABLE])
      | (ADDR_HOST & cfg[`B_ARP_ENABLE] & cfg[`B_HOST_ROLE_SEL]
         & cmd[`B_ACK_ENABLE])
      | (ADDR_ALERT_RESP & cmd[`B_ALERT_DRIVE]));

    // alert line is open drain: pull low only while the bit is set
    s_next.alert_oe   = cmd[`B_ALERT_DRIVE];

    // arbitration loss is not masked here; the checksum may be corrupted
    s_next.crc_on     = s_reg.unit_live & cfg[`B_CRC_CALC_ON];
    s_next.smbus_mode = cfg[`B_SMB_PROTO_SEL];
    s_next.ack_next   = cmd[`B_ACK_NEXT_SEL];
    s_next.data_ack   = cmd[`B_ACK_ENABLE];
    s_next.crc_req    = cmd[`B_CRC_XFER_REQ];

    // engine ends a master transfer or releases lines as a slave
    s_next.stop_req   = s_reg.unit_live & cmd[`B_STOP_REQ];
    s_next.start_req  = s_reg.unit_live & cmd[`B_START_REQ];
    s_next.hold_reset = cmd[`B_SOFT_HOLD_RST];
  end

  // reset picture
  //   both control registers and the irq enables clear to zero
  //   all engine controls and requests start low
  //   sync flops and edge stages start high, the idle pin level,
  //   so no false start or stop follows reset
  //   ready starts high, so the first transfer is taken at once
  //
  // single state register, synchronous reset
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s_reg             <= '0;
      s_reg.main_config <= `MAIN_CONFIG_RST;
      s_reg.bus_command <= `BUS_COMMAND_RST;
      s_reg.irq_enable  <= `IRQ_ENABLE_RST;
      s_reg.scl_sync    <= 2'h3;
      s_reg.sda_sync    <= 2'h3;
      s_reg.scl_prev    <= 1'b1;
      s_reg.sda_prev    <= 1'b1;
      s_reg.ready       <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state flops, except HRESP and ALERT_OUT, which are tied low
  // bus answer; every transfer ends okay
  assign HRDATA       = s_reg.rdata;
  assign HREADYOUT    = s_reg.ready;
  assign HRESP        = 1'b0;

  // alert pin is open drain: only ever pulled low
  assign ALERT_OUT    = 1'b0;
  assign ALERT_OE     = s_reg.alert_oe;

  // interrupt requests and wake-up lines
  assign EVENT_IRQ    = s_reg.evt_irq;
  assign ERROR_IRQ    = s_reg.err_irq;
  assign WAKE_WAIT    = s_reg.wake_wait;
  assign WAKE_HALT    = s_reg.wake_halt;

  // acknowledge and stretching controls
  assign SCL_STRETCH  = s_reg.stretch;
  assign ADDR_ACK     = s_reg.addr_ack;
  assign DATA_ACK     = s_reg.data_ack;
  assign ACK_NEXT_SEL = s_reg.ack_next;

  // checksum and protocol controls
  assign CRC_CALC_ON  = s_reg.crc_on;
  assign CRC_XFER_REQ = s_reg.crc_req;
  assign SMBUS_MODE   = s_reg.smbus_mode;

  // pin ownership, requests and engine reset
  assign PINS_OWNED   = s_reg.unit_live;
  assign STOP_REQ     = s_reg.stop_req;
  assign START_REQ    = s_reg.start_req;
  assign ENGINE_RESET = s_reg.hold_reset;

  // limitations
  //   soft reset holds the engine and wipes busy; register contents stay
  //   busy follows only conditions seen on the synchronised pins and the soft reset
  //   the alert line readback input is not used here
  //   rewriting bus_command while a request is pending may
  //   issue that request twice; software waits for the clear
  //   error requests end wait, never halt
  //   bus errors are never signalled; every response is okay

endmodule

// ### i2c_ctl_monitor.sv
// port-level assertion checker for the two-wire control block
`timescale 1ns/1ps
module i2c_ctl_monitor (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // bus answer
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // causes from the engine
  input wire logic HALT_WAKE_FLAG,
  input wire logic TARGET_HIT_FLAG,
  input wire logic BYTE_DONE_FLAG,
  input wire logic SLAVE_MODE,
  input wire logic TIMEOUT_EVT,
  // effects
  input wire logic EVENT_IRQ,
  input wire logic ERROR_IRQ,
  input wire logic WAKE_WAIT,
  input wire logic WAKE_HALT,
  input wire logic SCL_STRETCH,
  input wire logic PINS_OWNED,
  input wire logic STOP_REQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // one wait state only, so a stuck slave shows at once
  property p_one_wait; !HREADYOUT |=> HREADYOUT; endproperty
  property p_okay; HRESP == 1'b0; endproperty
  property p_err_wait; ERROR_IRQ |-> WAKE_WAIT; endproperty
  property p_evt_wait; EVENT_IRQ |-> WAKE_WAIT; endproperty
  property p_halt_src; WAKE_HALT |-> $past(HALT_WAKE_FLAG); endproperty
  property p_halt_evt; WAKE_HALT |-> EVENT_IRQ; endproperty
  property p_stretch;
    SCL_STRETCH |-> $past(SLAVE_MODE && (TARGET_HIT_FLAG || BYTE_DONE_FLAG));
  endproperty
  // a timeout sets the stop bit, seen two edges on
  property p_tmo_stop; TIMEOUT_EVT && PINS_OWNED |-> ##2 STOP_REQ; endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready held low");
  a_okay: assert property (p_okay) else $error("response not okay");
  a_err_wait: assert property (p_err_wait) else $error("error without wait wake");
  a_evt_wait: assert property (p_evt_wait) else $error("event without wait wake");
  a_halt_src: assert property (p_halt_src) else $error("halt wake without flag");
  a_halt_evt: assert property (p_halt_evt) else $error("halt wake without event");
  a_stretch: assert property (p_stretch) else $error("stretch without cause");
  a_tmo_stop: assert property (p_tmo_stop) else $error("timeout did not set stop");
  // main scenarios reached
  c_halt: cover property (EVENT_IRQ && WAKE_HALT);
  c_err: cover property (ERROR_IRQ);
  c_stop: cover property ($rose(STOP_REQ));
endmodule

bind i2c_ctl i2c_ctl_monitor i2c_ctl_monitor_i (
  .CORE_CLK(CORE_CLK), .RST(RST), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .HALT_WAKE_FLAG(HALT_WAKE_FLAG), .TARGET_HIT_FLAG(TARGET_HIT_FLAG),
  .BYTE_DONE_FLAG(BYTE_DONE_FLAG), .SLAVE_MODE(SLAVE_MODE), .TIMEOUT_EVT(TIMEOUT_EVT),
  .EVENT_IRQ(EVENT_IRQ), .ERROR_IRQ(ERROR_IRQ), .WAKE_WAIT(WAKE_WAIT), .WAKE_HALT(WAKE_HALT),
  .SCL_STRETCH(SCL_STRETCH), .PINS_OWNED(PINS_OWNED), .STOP_REQ(STOP_REQ)
);

// ### bus_peer.sv
// far-side bus peer making start and stop conditions at the link rate
`timescale 1ns/1ps
module bus_peer #(
  parameter real HALF_NS = 62.5
) (
  // lines as seen at the pins
  output logic scl_line,
  output logic sda_line
);
  // pull-ups keep both lines high, clock still between frames
  initial begin
    scl_line = 1'b1;
    sda_line = 1'b1;
  end
  // data falls while the clock is high, then the clock goes low
  task automatic start_cond();
    scl_line = 1'b1;
    #(HALF_NS) sda_line = 1'b0;
    #(HALF_NS) scl_line = 1'b0;
  endtask
  // data rises while the clock is high; lines left free after
  task automatic stop_cond();
    sda_line = 1'b0;
    #(HALF_NS) scl_line = 1'b1;
    #(HALF_NS) sda_line = 1'b1;
    #(HALF_NS);
  endtask
endmodule

// ### test_i2c_irq_and_control.sv
// self-checking bench for the two-wire control block
`timescale 1ns/1ps
`include "ctl_cfg.svh"
module test_i2c_irq_and_control;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rv;
  logic        hready;
  logic        hresp;
  logic [5:0]  evt = 6'h0;
  logic [1:0]  bfl = 2'h0;
  logic [6:0]  err = 7'h0;
  logic [4:0]  adr = 5'h0;
  logic [2:0]  pls = 3'h0;
  logic        slave = 1'b0;
  wire [15:0]  o;
  wire         scl;
  wire         sda;
  int          bad_count = 0;
  int          checks = 0;
  int          cycles = 0;
  logic [7:0]  cfg_t [8] = '{8'h41, 8'h01, 8'h13, 8'h1B, 8'h1B, 8'h03, 8'h01, 8'h01};
  logic [7:0]  cmd_t [8] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h20, 8'h00, 8'h04};
  int          cls_t [8] = '{1, 1, 2, 2, 3, 4, 0, 0};
  logic [7:0]  ack_t = 8'hB5;

  always #5 clk = ~clk;
  // o: irq evt/err, wake wait/halt, stretch, acks, pos, crc, smbus, owned, stop, start, rst, alert
  i2c_ctl i2c_ctl_i (
    .CORE_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
    .HRESP(hresp), .SCL_IN(scl), .SDA_IN(sda), .ALERT_IN(1'b1), .ALERT_OUT(), .ALERT_OE(o[15]),
    .START_SENT_FLAG(evt[0]), .TARGET_HIT_FLAG(evt[1]), .TEN_BIT_HEADER_FLAG(evt[2]),
    .STOP_SEEN_FLAG(evt[3]), .BYTE_DONE_FLAG(evt[4]), .HALT_WAKE_FLAG(evt[5]),
    .RX_HOLDING_FULL(bfl[0]), .TX_HOLDING_EMPTY(bfl[1]), .MISPLACED_COND_FLAG(err[0]),
    .ARB_LOST_FLAG(err[1]), .NAK_FAULT_FLAG(err[2]), .OVERFLOW_UNDERFLOW_FLAG(err[3]),
    .CRC_MISMATCH_FLAG(err[4]), .TIMEOUT_FLAG(err[5]), .SMBUS_ALERT_FLAG(err[6]),
    .SLAVE_MODE(slave), .START_DONE(pls[0]), .CRC_SENT(pls[1]), .TIMEOUT_EVT(pls[2]),
    .ADDR_OWN(adr[0]), .ADDR_GEN_CALL(adr[1]), .ADDR_DEV_DEFAULT(adr[2]), .ADDR_HOST(adr[3]),
    .ADDR_ALERT_RESP(adr[4]), .EVENT_IRQ(o[0]), .ERROR_IRQ(o[1]), .WAKE_WAIT(o[2]),
    .WAKE_HALT(o[3]), .SCL_STRETCH(o[4]), .ADDR_ACK(o[5]), .DATA_ACK(o[6]), .ACK_NEXT_SEL(o[7]),
    .CRC_CALC_ON(o[8]), .CRC_XFER_REQ(o[9]), .SMBUS_MODE(o[10]), .PINS_OWNED(o[11]),
    .STOP_REQ(o[12]), .START_REQ(o[13]), .ENGINE_RESET(o[14]));
  bus_peer bus_peer_i (.scl_line(scl), .sda_line(sda));

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // waits past the edge so its updates have landed
  task automatic look(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one single ahb transfer; address held until ready, data until ready again
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, idx, 2'h0};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    rv = hrdata;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [9:0] idx, input logic [31:0] exp, input string nm);
    xfer(1'b0, idx, 8'h00);
    chk(rv, exp, nm);
  endtask
  task automatic pulse(input logic [2:0] p);
    @(posedge clk);
    pls <= p;
    @(posedge clk);
    pls <= 3'h0;
    look(2);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(`IDX_MAIN_CONFIG, 32'h0, "main_config reset");
    rdc(`IDX_BUS_COMMAND, 32'h0, "bus_command reset");
    chk(32'(o), 32'h0, "outputs after reset");
    rdc(10'h020, 32'h0, "unmapped read");
    wr(`IDX_MAIN_CONFIG, 8'hFF);
    rdc(`IDX_MAIN_CONFIG, 32'hFB, "main_config bit two");
    look(2);
    chk(32'(o[11:8]), 32'hD, "crc smbus owned");
    wr(`IDX_BUS_COMMAND, 8'hC0);
    rdc(`IDX_BUS_COMMAND, 32'h80, "bus_command reserved");
    chk(32'(o[14]), 32'h1, "engine reset held");
    wr(`IDX_BUS_COMMAND, 8'h00);
    look(2);
    chk(32'(o[14]), 32'h0, "engine reset released");
    // every event flag, halt wake only from its own flag
    wr(`IDX_MAIN_CONFIG, 8'h01);
    wr(`IDX_IRQ_ENABLE, 8'h02);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      evt <= 6'(1 << k);
      look(2);
      chk(32'(o[3:0]), k == 5 ? 32'hD : 32'h5, "event irq wake");
    end
    @(posedge clk);
    evt <= 6'h10;
    slave <= 1'b1;
    look(2);
    chk(32'(o[4]), 32'h1, "slave stretch");
    wr(`IDX_MAIN_CONFIG, 8'h81);
    look(2);
    chk(32'(o[4]), 32'h0, "stretch disabled");
    @(posedge clk);
    evt <= 6'h0;
    // buffer flags need both enables
    for (int k = 0; k < 4; k++) begin
      wr(`IDX_IRQ_ENABLE, k == 0 ? 8'h02 : (k == 2 ? 8'h04 : 8'h06));
      bfl <= k[1] ? 2'h2 : 2'h1;
      slave <= 1'b0;
      look(2);
      chk(32'(o[0]), 32'(k[0]), "buffer irq");
    end
    wr(`IDX_IRQ_ENABLE, 8'h01);
    bfl <= 2'h0;
    for (int k = 0; k < 8; k++) begin
      if (k == 7) wr(`IDX_IRQ_ENABLE, 8'h00);
      @(posedge clk);
      err <= 7'(1 << (k % 7));
      look(2);
      chk(32'(o[3:0]), k == 7 ? 32'h0 : 32'h6, "error irq wake");
    end
    // address classes against the config and ack bits
    for (int k = 0; k < 8; k++) begin
      wr(`IDX_MAIN_CONFIG, cfg_t[k]);
      wr(`IDX_BUS_COMMAND, cmd_t[k]);
      adr <= 5'(1 << cls_t[k]);
      look(2);
      chk(32'(o[5]), 32'(ack_t[k]), "address ack");
      chk(32'({o[15], o[6]}), 32'({cmd_t[k][5], cmd_t[k][2]}), "alert data ack");
    end
    // hardware clears of the requests; no rewrite until cleared
    wr(`IDX_BUS_COMMAND, 8'h11);
    look(1);
    chk(32'({o[13], o[9]}), 32'h3, "requests set");
    pulse(3'h1);
    chk(32'({o[13], o[12], o[9]}), 32'h1, "start sent");
    pulse(3'h2);
    chk(32'(o[9]), 32'h0, "crc sent");
    wr(`IDX_BUS_COMMAND, 8'h10);
    bus_peer_i.start_cond();
    look(6);
    chk(32'(o[9]), 32'h0, "crc cleared by start");
    pulse(3'h4);
    chk(32'(o[12]), 32'h1, "timeout sets stop");
    bus_peer_i.stop_cond();
    look(6);
    chk(32'(o[12]), 32'h0, "stop cleared");
    // disable mid-transfer waits for the bus to go idle
    wr(`IDX_BUS_COMMAND, 8'h2C);
    bus_peer_i.start_cond();
    wr(`IDX_MAIN_CONFIG, 8'h00);
    look(4);
    chk(32'({o[15], o[11], o[7], o[6]}), 32'hF, "deferred disable");
    bus_peer_i.stop_cond();
    look(6);
    chk(32'({o[15], o[11], o[7], o[6]}), 32'h0, "idle disable");
    rdc(`IDX_BUS_COMMAND, 32'h0, "bits cleared by disable");
    results();
  end
endmodule
